/* File: inc/plcc_pkg.sv */
// Shared constants and types of the per-port link configuration block
package plcc_pkg;

    // ****************************************************************
    // Register map (byte addresses, one 32-bit word each)
    // ****************************************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ADV = 8'h04;
    localparam logic [7:0] OFS_UPLINK = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_ADV_STATUS = 8'h10;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h18;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h1c;

    // ****************************************************************
    // Control word fields (also status word layout where shared)
    // ****************************************************************
    localparam int F_ADMIN_UP = 0;
    localparam int F_ANEG = 1;
    localparam int F_SPEED = 2;
    localparam int F_FULL = 4;
    localparam int F_BP = 5;
    localparam int F_FC = 6;
    localparam int F_XOVER = 7;
    localparam int F_PRIV_EDGE = 9;
    localparam int F_AGG = 10;
    localparam int F_REACTIVATE = 11;
    localparam int F_ADV_MAX = 5;
    localparam int F_ACTIVE = 0;
    localparam int F_SUSPENDED = 11;
    localparam int F_NEG_DONE = 12;
    localparam int F_NEIGH = 8;

    // ****************************************************************
    // Encodings
    // ****************************************************************
    localparam logic [1:0] SPD_10 = 2'h0;
    localparam logic [1:0] SPD_100 = 2'h1;
    localparam logic [1:0] SPD_1000 = 2'h2;
    localparam logic [1:0] XO_AUTO = 2'h0;
    localparam logic [1:0] XO_STRAIGHT = 2'h1;
    localparam logic [1:0] XO_CROSSED = 2'h2;
    localparam int ADV_W = 5;
    localparam int ADV_10H = 0;
    localparam int ADV_10F = 1;
    localparam int ADV_100H = 2;
    localparam int ADV_100F = 3;
    localparam int ADV_1000F = 4;
    localparam logic [4:0] ADV_ALL = 5'h1f;
    localparam int EV_W = 4;
    localparam int EV_LINK = 0;
    localparam int EV_NEG_DONE = 1;
    localparam int EV_SUSPEND = 2;
    localparam int EV_NEIGH = 3;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic RST_ADMIN_UP = 1'b1;
    localparam logic RST_ANEG = 1'b1;
    localparam logic [1:0] RST_SPEED = SPD_100;
    localparam logic RST_FULL = 1'b1;
    localparam logic RST_BP = 1'b0;
    localparam logic RST_FC = 1'b0;
    localparam logic [1:0] RST_XOVER = XO_AUTO;
    localparam logic [4:0] RST_ADV = ADV_ALL;

    // Negotiation progress, Gray along idle, wait, done
    typedef enum logic [1:0] {
        NEG_IDLE = 2'b00,
        NEG_WAIT = 2'b01,
        NEG_DONE = 2'b11
    } plcc_neg_t;

endpackage : plcc_pkg

/* File: design/plcc_port_ctrl.sv */
// Per-port link configuration, negotiation result and status block
//
// How it works
// [RQ1] Admin down takes the port offline; admin up lets it carry traffic.
// [RQ2] Forced speed is accepted only with auto-negotiation off; otherwise negotiated speed rules.
// [RQ3] Forced duplex applies only with negotiation off and forced speed 10 or 100.
// [RQ4] Duplex cannot be changed while the port is an aggregation group.
// [RQ5] Flow control is active only in full duplex, never in half.
// [RQ6] Private edge port skips the lookup and sends everything to the uplink.
// [RQ7] Advertisement holds any mix of five abilities; max capability selects all five.
// [RQ8] Own abilities go out to the neighbour; neighbour abilities are captured for readback.
// [RQ9] Crossover is automatic, straight or crossed; the current mode is readable.
// [RQ10] A suspended port stays suspended until management asks for reactivation.
// [RQ11] Back-pressure has an enable and its current state is reported.
// [RQ12] Flow control has an enable and its current state is reported.
// [RQ13] Software should turn negotiation off on ports with pluggable optical modules.
// [RQ14] Status shows active, speed, duplex and negotiation apart from the settings.
// [RQ15] Negotiation picks the highest common ability, full before half at equal speed.
module plcc_port_ctrl
    import plcc_pkg::*;
#(
    parameter int NPORTS = 8
)
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    input wire logic link_up_pin,
    input wire logic partner_adv_valid_pin,
    input wire logic [ADV_W-1:0] partner_adv_pin,
    input wire logic cable_crossed_pin,
    input wire logic port_suspend,
    input wire logic [NPORTS-1:0] fdb_dest_mask,
    output logic [NPORTS-1:0] fwd_dest_mask,
    output logic fdb_bypass,
    output logic [ADV_W-1:0] local_adv,
    output logic port_enable,
    output logic [1:0] op_speed,
    output logic op_full_duplex,
    output logic fc_active,
    output logic bp_active,
    output logic cable_crossed
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    if (NPORTS < 1 || NPORTS > 32)
    begin : g_bad_nports
        $error("NPORTS must lie between 1 and 32");
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Highest common ability: {ok, speed, full}
    function automatic logic [3:0] plcc_resolve(input logic [ADV_W-1:0] common);
        logic [3:0] res;
        res = 4'h0;
        if (common[ADV_1000F])
            res = {1'b1, SPD_1000, 1'b1}; // RQ15
        else if (common[ADV_100F])
            res = {1'b1, SPD_100, 1'b1};
        else if (common[ADV_100H])
            res = {1'b1, SPD_100, 1'b0};
        else if (common[ADV_10F])
            res = {1'b1, SPD_10, 1'b1};
        else if (common[ADV_10H])
            res = {1'b1, SPD_10, 1'b0};
        return res;
    endfunction : plcc_resolve

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [ADV_W+2:0] sync_a;
    logic [ADV_W+2:0] sync_b;
    logic link_up;
    logic partner_valid;
    logic [ADV_W-1:0] partner_adv;
    logic crossed_detect;
    logic link_up_d;
    logic partner_valid_d;

    // Two flops per pin; only sync_b is read by logic
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sync_a <= '0;
            sync_b <= '0;
            {link_up_d, partner_valid_d} <= 2'b00;
        end
        else
        begin
            sync_a <= {link_up_pin, partner_adv_valid_pin, cable_crossed_pin, partner_adv_pin};
            sync_b <= sync_a;
            {link_up_d, partner_valid_d} <= {link_up, partner_valid};
        end
    end

    assign link_up = sync_b[ADV_W+2];
    assign partner_valid = sync_b[ADV_W+1];
    assign crossed_detect = sync_b[ADV_W];
    assign partner_adv = sync_b[ADV_W-1:0];

    // ****************************************************************
    // Register decode
    // ****************************************************************
    logic wr_ctrl, wr_adv, wr_uplink, wr_clear, wr_enable;

    assign wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
    assign wr_adv = reg_wr && (reg_addr == OFS_ADV);
    assign wr_uplink = reg_wr && (reg_addr == OFS_UPLINK);
    assign wr_clear = reg_wr && (reg_addr == OFS_IRQ_CLEAR);
    assign wr_enable = reg_wr && (reg_addr == OFS_IRQ_ENABLE);

    // ****************************************************************
    // Configuration state
    // ****************************************************************
    logic admin_up, next_admin_up;
    logic aneg_en, next_aneg_en;
    logic [1:0] force_speed, next_force_speed;
    logic force_full, next_force_full;
    logic bp_en, next_bp_en;
    logic fc_en, next_fc_en;
    logic [1:0] xover_mode, next_xover_mode;
    logic priv_edge, next_priv_edge;
    logic agg_group, next_agg_group;
    logic [ADV_W-1:0] adv, next_adv;
    logic [NPORTS-1:0] uplink, next_uplink;
    logic suspended, next_suspended;

    // Speed and duplex are checked against the word being written, so one
    // write may turn negotiation off and force the link in the same cycle
    always_comb
    begin
        {next_admin_up, next_aneg_en, next_force_speed, next_force_full, next_bp_en, next_fc_en} =
            {admin_up, aneg_en, force_speed, force_full, bp_en, fc_en};
        {next_xover_mode, next_priv_edge, next_agg_group, next_adv, next_uplink} =
            {xover_mode, priv_edge, agg_group, adv, uplink};
        if (wr_ctrl)
        begin
            next_admin_up = reg_wdata[F_ADMIN_UP]; // RQ1
            next_aneg_en = reg_wdata[F_ANEG];
            next_bp_en = reg_wdata[F_BP]; // RQ11
            next_fc_en = reg_wdata[F_FC]; // RQ12
            next_priv_edge = reg_wdata[F_PRIV_EDGE];
            next_agg_group = reg_wdata[F_AGG];
            if (reg_wdata[F_XOVER+1:F_XOVER] != 2'h3)
                next_xover_mode = reg_wdata[F_XOVER+1:F_XOVER]; // RQ9
            if (!reg_wdata[F_ANEG] && reg_wdata[F_SPEED+1:F_SPEED] != 2'h3)
                next_force_speed = reg_wdata[F_SPEED+1:F_SPEED]; // RQ2
            if (!reg_wdata[F_ANEG] && !agg_group && next_force_speed != SPD_1000) // RQ4
                next_force_full = reg_wdata[F_FULL]; // RQ3
        end
        if (wr_adv)
            next_adv = reg_wdata[F_ADV_MAX] ? ADV_ALL : reg_wdata[ADV_W-1:0]; // RQ7
        if (wr_uplink)
            next_uplink = reg_wdata[NPORTS-1:0];
        // A new suspension in the reactivation cycle wins
        next_suspended = port_suspend | (suspended & ~(wr_ctrl & reg_wdata[F_REACTIVATE])); // RQ10
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            {admin_up, aneg_en, force_speed, force_full} <= {RST_ADMIN_UP, RST_ANEG, RST_SPEED, RST_FULL};
            {bp_en, fc_en, xover_mode, adv} <= {RST_BP, RST_FC, RST_XOVER, RST_ADV};
            {priv_edge, agg_group, suspended} <= 3'b000;
            uplink <= '0;
        end
        else
        begin
            {admin_up, aneg_en, force_speed} <= {next_admin_up, next_aneg_en, next_force_speed};
            {force_full, bp_en, fc_en} <= {next_force_full, next_bp_en, next_fc_en};
            {xover_mode, priv_edge, agg_group} <= {next_xover_mode, next_priv_edge, next_agg_group};
            {adv, uplink, suspended} <= {next_adv, next_uplink, next_suspended};
        end
    end

    // ****************************************************************
    // Negotiation
    // ****************************************************************
    plcc_neg_t neg_state, next_neg_state;
    logic [ADV_W-1:0] neigh_adv, next_neigh_adv;
    logic [1:0] neg_speed, next_neg_speed;
    logic neg_full, next_neg_full;
    logic neigh_new;
    logic [3:0] resolved;

    // Neighbour word is taken on the rising edge of its valid, settled by then
    assign neigh_new = partner_valid & ~partner_valid_d;
    assign resolved = plcc_resolve(adv & partner_adv);

    // Own advertisement change restarts the exchange
    always_comb
    begin
        next_neg_state = neg_state;
        {next_neg_speed, next_neg_full, next_neigh_adv} = {neg_speed, neg_full, neigh_adv};
        if (neigh_new)
            next_neigh_adv = partner_adv; // RQ8
        case (neg_state)
            NEG_IDLE:
                if (aneg_en && link_up)
                    next_neg_state = NEG_WAIT;
            NEG_WAIT:
                if (!aneg_en || !link_up)
                    next_neg_state = NEG_IDLE;
                else if (neigh_new && resolved[3])
                begin
                    next_neg_state = NEG_DONE;
                    next_neg_speed = resolved[2:1]; // RQ15
                    next_neg_full = resolved[0];
                end
            NEG_DONE:
                if (!aneg_en || !link_up)
                    next_neg_state = NEG_IDLE;
                else if (wr_adv)
                    next_neg_state = NEG_WAIT;
            default:
                next_neg_state = NEG_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            neg_state <= NEG_IDLE;
            {neg_speed, neg_full, neigh_adv} <= {SPD_10, 1'b0, {ADV_W{1'b0}}};
        end
        else
        begin
            neg_state <= next_neg_state;
            {neg_speed, neg_full, neigh_adv} <= {next_neg_speed, next_neg_full, next_neigh_adv};
        end
    end

    // ****************************************************************
    // Operating outputs
    // ****************************************************************
    logic active, cur_full, neg_ok;
    logic [1:0] cur_speed;

    assign neg_ok = (neg_state == NEG_DONE);
    assign active = admin_up & ~suspended & link_up & (~aneg_en | neg_ok); // RQ1 RQ10
    assign cur_speed = aneg_en ? neg_speed : force_speed; // RQ2
    // Forced gigabit is full duplex only
    assign cur_full = aneg_en ? neg_full : (force_full | (force_speed == SPD_1000)); // RQ3

    // All operating outputs come from flops, one cycle after the state
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            {port_enable, op_speed, op_full_duplex} <= {1'b0, SPD_10, 1'b0};
            {fc_active, bp_active, cable_crossed, fdb_bypass} <= 4'h0;
            local_adv <= '0;
            fwd_dest_mask <= '0;
        end
        else
        begin
            port_enable <= active; // RQ1
            op_speed <= cur_speed;
            op_full_duplex <= cur_full;
            fc_active <= fc_en & cur_full & active; // RQ5
            bp_active <= bp_en & ~cur_full & active; // RQ11
            cable_crossed <= (xover_mode == XO_AUTO) ? crossed_detect : (xover_mode == XO_CROSSED); // RQ9
            local_adv <= aneg_en ? adv : '0; // RQ8
            fdb_bypass <= priv_edge; // RQ6
            fwd_dest_mask <= priv_edge ? uplink : fdb_dest_mask; // RQ6
        end
    end

    // ****************************************************************
    // Interrupts
    // ****************************************************************
    logic [EV_W-1:0] irq_status, next_irq_status;
    logic [EV_W-1:0] irq_enable, next_irq_enable;
    logic [EV_W-1:0] events;

    assign events[EV_LINK] = link_up ^ link_up_d;
    assign events[EV_NEG_DONE] = (next_neg_state == NEG_DONE) && (neg_state != NEG_DONE);
    assign events[EV_SUSPEND] = port_suspend & ~suspended;
    assign events[EV_NEIGH] = neigh_new;

    // Set beats clear in the same cycle
    always_comb
    begin
        next_irq_status = irq_status;
        next_irq_enable = irq_enable;
        if (wr_clear)
            next_irq_status = irq_status & ~reg_wdata[EV_W-1:0];
        next_irq_status = next_irq_status | events;
        if (wr_enable)
            next_irq_enable = reg_wdata[EV_W-1:0];
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            {irq_status, irq_enable} <= {(2 * EV_W){1'b0}};
        end
        else
        begin
            {irq_status, irq_enable} <= {next_irq_status, next_irq_enable};
        end
    end

    assign irq = |(irq_status & irq_enable);

    // ****************************************************************
    // Read path
    // ****************************************************************
    logic [31:0] rd_word;
    logic [1:0] cur_xover;

    assign cur_xover = cable_crossed ? XO_CROSSED : XO_STRAIGHT;

    // Unmapped and write-only offsets read as zero
    always_comb
    begin
        rd_word = 32'h0;
        case (reg_addr)
            OFS_CTRL:
                rd_word[F_AGG:F_ADMIN_UP] = {agg_group, priv_edge, xover_mode, fc_en, bp_en, force_full, force_speed,
                    aneg_en, admin_up};
            OFS_ADV:
                rd_word[ADV_W-1:0] = adv;
            OFS_UPLINK:
                rd_word[NPORTS-1:0] = uplink;
            OFS_STATUS:
                rd_word[F_NEG_DONE:F_ACTIVE] = {neg_ok, suspended, 2'b00, cur_xover, fc_en, bp_en, cur_full, cur_speed,
                    aneg_en, active}; // RQ14 RQ11 RQ12 RQ9
            OFS_ADV_STATUS:
                rd_word[F_NEIGH+ADV_W-1:0] = {neigh_adv, 3'b000, local_adv}; // RQ8
            OFS_IRQ_STATUS:
                rd_word[EV_W-1:0] = irq_status;
            OFS_IRQ_ENABLE:
                rd_word[EV_W-1:0] = irq_enable;
            default:
                rd_word = 32'h0;
        endcase
    end

    // Data stand only in the cycle after the strobe
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            reg_rdata <= 32'h0;
        else
            reg_rdata <= reg_rd ? rd_word : 32'h0;
    end

endmodule : plcc_port_ctrl

/* File: testbench/plcc_port_ctrl_monitor.sv */
// Concurrent checks on the port link configuration block
module plcc_port_ctrl_monitor
    import plcc_pkg::*;
#(
    parameter int NPORTS = 8
)
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic port_suspend,
    input wire logic [NPORTS-1:0] fdb_dest_mask,
    input wire logic [NPORTS-1:0] fwd_dest_mask,
    input wire logic fdb_bypass,
    input wire logic [ADV_W-1:0] local_adv,
    input wire logic port_enable,
    input wire logic [1:0] op_speed,
    input wire logic op_full_duplex,
    input wire logic fc_active,
    input wire logic bp_active
);
    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking mon_cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    // Control writes whose effect lands two edges later
    sequence s_wr_admin_down;
        reg_wr && reg_addr == OFS_CTRL && !reg_wdata[F_ADMIN_UP];
    endsequence
    sequence s_wr_aneg_off;
        reg_wr && reg_addr == OFS_CTRL && !reg_wdata[F_ANEG];
    endsequence

    a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside its slot");
    a_fc_full_only: assert property (fc_active |-> op_full_duplex)
        else $error("flow control active in half duplex");
    a_bp_half_only: assert property (bp_active |-> !op_full_duplex)
        else $error("back pressure active in full duplex");
    a_offline_quiet: assert property (!port_enable |-> !fc_active && !bp_active)
        else $error("pause logic active on offline port");
    a_fwd_follow_fdb: assert property (!fdb_bypass |-> fwd_dest_mask == $past(fdb_dest_mask))
        else $error("forward mask differs from lookup result");
    a_gig_full_duplex: assert property (port_enable && op_speed == SPD_1000 |-> op_full_duplex)
        else $error("gigabit speed without full duplex");
    a_admin_down_off: assert property (s_wr_admin_down |-> ##2 !port_enable)
        else $error("port still enabled after admin down");
    a_suspend_off: assert property (port_suspend |-> ##2 !port_enable)
        else $error("port still enabled after suspension");
    a_aneg_off_adv: assert property (s_wr_aneg_off |-> ##2 local_adv == '0)
        else $error("advertisement sent with negotiation off");
endmodule : plcc_port_ctrl_monitor

/* File: testbench/plcc_neighbour_model.sv */
// Behavioural neighbour port: link, crossover sense and advertisement
module plcc_neighbour_model
    import plcc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic link_req,
    input wire logic cross_req,
    input wire logic send_req,
    input wire logic [ADV_W-1:0] adv_word,
    output logic link_up_pin,
    output logic partner_adv_valid_pin,
    output logic [ADV_W-1:0] partner_adv_pin,
    output logic cable_crossed_pin
);
    logic send_q;
    logic [ADV_W-1:0] last_adv;

    // Word goes out one cycle ahead of valid so the port never sees it mid-change
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            send_q <= 1'b0;
            last_adv <= '0;
            link_up_pin <= 1'b0;
            cable_crossed_pin <= 1'b0;
            partner_adv_valid_pin <= 1'b0;
        end
        else
        begin
            link_up_pin <= link_req;
            cable_crossed_pin <= cross_req;
            send_q <= send_req;
            partner_adv_valid_pin <= send_q && send_req;
            if (send_req && !send_q)
            begin
                last_adv <= adv_word;
            end
        end
    end

    // Released word lines show the inverse so stale data cannot pass for a match
    assign partner_adv_pin = (send_q || partner_adv_valid_pin) ? last_adv : ~last_adv;
endmodule : plcc_neighbour_model

/* File: testbench/plcc_port_ctrl_tb.sv */
// Self-checking bench of the port link configuration block
module plcc_port_ctrl_tb
    import plcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic reg_wr = 1'b0, reg_rd = 1'b0, port_suspend = 1'b0, irq;
    logic link_req = 1'b0, send_req = 1'b0, cross_req = 1'b0;
    logic [4:0] adv_word = 5'h00, local_adv, partner_adv_pin;
    logic link_up_pin, partner_adv_valid_pin, cable_crossed_pin, fdb_bypass, port_enable;
    logic op_full_duplex, fc_active, bp_active, cable_crossed;
    logic [7:0] fdb_dest_mask = 8'h00, fwd_dest_mask;
    logic [1:0] op_speed;
    int n_mismatch = 0, checks = 0, cycles = 0;

    plcc_port_ctrl #(.NPORTS(8)) DUT (.clk_sys, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
        .link_up_pin, .partner_adv_valid_pin, .partner_adv_pin, .cable_crossed_pin, .port_suspend, .fdb_dest_mask,
        .fwd_dest_mask, .fdb_bypass, .local_adv, .port_enable, .op_speed, .op_full_duplex, .fc_active, .bp_active,
        .cable_crossed);
    plcc_neighbour_model u_nb (.clk_sys, .arst_n, .link_req, .cross_req, .send_req, .adv_word, .link_up_pin,
        .partner_adv_valid_pin, .partner_adv_pin, .cable_crossed_pin);

    // ****************************************************************
    // Clock, watchdog and access tasks
    // ****************************************************************
    initial
    begin
        forever #4 clk_sys = ~clk_sys;
    end

    // Whole run needs well under a thousand cycles; the ceiling leaves ample slack
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_mismatch = n_mismatch + 1;
            stop_test();
        end
    end

    task automatic stop_test();
        if (n_mismatch == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks = checks + 1;
        if (got !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk("read data", exp, reg_rdata);
    endtask : rd

    task automatic ost(input logic [5:0] e);
        chk("port state", 32'(e), 32'({port_enable, op_speed, op_full_duplex, fc_active, bp_active}));
    endtask : ost

    // Neighbour sends one advertisement, then releases the lines
    task automatic nb(input logic [4:0] w);
        @(posedge clk_sys);
        adv_word <= w;
        send_req <= 1'b1;
        tick(8);
        send_req <= 1'b0;
        tick(6);
    endtask : nb

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial
    begin
        tick(12);
        arst_n <= 1'b1;
        rd(OFS_CTRL, 32'h17);
        rd(OFS_ADV_STATUS, 32'h1f);
        rd(8'h20, 32'h0);
        wr(OFS_IRQ_ENABLE, 32'h8);
        link_req <= 1'b1;
        tick(6);
        nb(5'h0f);
        ost({1'b1, SPD_100, 1'b1, 2'b00});
        chk("irq", 32'h1, 32'(irq));
        rd(OFS_ADV_STATUS, 32'h0f1f);
        rd(OFS_STATUS, 32'h1097);
        rd(OFS_IRQ_STATUS, 32'h0b);
        wr(OFS_IRQ_CLEAR, 32'hf);
        wr(OFS_IRQ_ENABLE, 32'h0);
        chk("irq", 32'h0, 32'(irq));
        wr(OFS_ADV, 32'h08);
        nb(5'h03);
        chk("port enable", 32'h0, 32'(port_enable));
        wr(OFS_ADV, 32'h20);
        rd(OFS_ADV_STATUS, 32'h031f);
        nb(5'h13);
        ost({1'b1, SPD_1000, 1'b1, 2'b00});
        chk("irq", 32'h0, 32'(irq));
        rd(OFS_IRQ_STATUS, 32'h0a);
        wr(OFS_CTRL, 32'h61);
        tick(3);
        ost({1'b1, SPD_10, 1'b0, 1'b0, 1'b1});
        chk("own advertisement", 32'h0, 32'(local_adv));
        rd(OFS_STATUS, 32'he1);
        wr(OFS_CTRL, 32'h69);
        tick(3);
        ost({1'b1, SPD_1000, 1'b1, 1'b1, 1'b0});
        wr(OFS_CTRL, 32'h415);
        wr(OFS_CTRL, 32'h405);
        tick(3);
        ost({1'b1, SPD_100, 1'b1, 2'b00});
        fdb_dest_mask <= 8'h05;
        wr(OFS_UPLINK, 32'h80);
        wr(OFS_CTRL, 32'h605);
        tick(3);
        chk("forward mask", 32'h180, 32'({fdb_bypass, fwd_dest_mask}));
        wr(OFS_CTRL, 32'h405);
        tick(3);
        chk("forward mask", 32'h005, 32'({fdb_bypass, fwd_dest_mask}));
        cross_req <= 1'b1;
        for (int m = 0; m < 3; m++)
        begin
            wr(OFS_CTRL, 32'h405 | (m << 7));
            tick(5);
            chk("crossover", 32'(m != 1), 32'(cable_crossed));
        end
        wr(OFS_CTRL, 32'h404);
        tick(3);
        chk("port enable", 32'h0, 32'(port_enable));
        rd(OFS_CTRL, 32'h414);
        wr(OFS_CTRL, 32'h405);
        tick(3);
        chk("port enable", 32'h1, 32'(port_enable));
        port_suspend <= 1'b1;
        tick(1);
        port_suspend <= 1'b0;
        tick(20);
        chk("port enable", 32'h0, 32'(port_enable));
        rd(OFS_STATUS, 32'h914);
        rd(OFS_IRQ_STATUS, 32'he);
        wr(OFS_CTRL, 32'hc05);
        tick(3);
        chk("port enable", 32'h1, 32'(port_enable));
        stop_test();
    end
endmodule : plcc_port_ctrl_tb

bind plcc_port_ctrl plcc_port_ctrl_monitor #(.NPORTS(NPORTS)) u_mon (.clk_sys, .arst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .port_suspend, .fdb_dest_mask, .fwd_dest_mask, .fdb_bypass, .local_adv,
    .port_enable, .op_speed, .op_full_duplex, .fc_active, .bp_active);
